/* addr_gen_pkg.sv */
// Constants, opcodes and control word layout of the address generator front end.
// Assumes a single 200 MHz clock and a 10-bit microcode instruction word.
package addr_gen_pkg;

  // ===========================================================================
  // Widths
  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned INSTR_W = 10;
  localparam int unsigned ALT_W   = 10;
  localparam int unsigned NUM_R   = 8;
  localparam int unsigned NUM_B   = 8;
  localparam int unsigned NUM_CI  = 4;
  localparam int unsigned CR_W    = 11;

  // ===========================================================================
  // Instruction fields: opcode, first and second register index
  localparam int unsigned OPC_HI = 9;
  localparam int unsigned OPC_LO = 6;
  localparam int unsigned FA_HI  = 5;
  localparam int unsigned FA_LO  = 3;
  localparam int unsigned FB_HI  = 2;
  localparam int unsigned FB_LO  = 0;

  // ===========================================================================
  // Opcodes
  localparam logic [3:0] OP_NOP        = 4'h0;
  localparam logic [3:0] OP_LOOP_ADD   = 4'h1;
  localparam logic [3:0] OP_LOOP_SUB   = 4'h2;
  localparam logic [3:0] OP_LOOP_INC   = 4'h3;
  localparam logic [3:0] OP_LOOP_DEC   = 4'h4;
  localparam logic [3:0] OP_LOGIC_OR   = 4'h5;
  localparam logic [3:0] OP_LOGIC_AND  = 4'h6;
  localparam logic [3:0] OP_LOGIC_XOR  = 4'h7;
  localparam logic [3:0] OP_ASR        = 4'h8;
  localparam logic [3:0] OP_LSL        = 4'h9;
  localparam logic [3:0] OP_XFER_ADDR  = 4'hA;
  localparam logic [3:0] OP_XFER_OFS   = 4'hB;
  localparam logic [3:0] OP_XFER_CMP   = 4'hC;
  localparam logic [3:0] OP_BIT_REV    = 4'hD;
  localparam logic [3:0] OP_MISC       = 4'hF;

  // Sub-operations of OP_MISC, held in the first register field
  localparam logic [2:0] SUB_WRITE_ALT   = 3'h0;
  localparam logic [2:0] SUB_CAPTURE_ALT = 3'h1;
  localparam logic [2:0] SUB_SET_PREC    = 3'h2;
  localparam logic [2:0] SUB_LOAD_INIT   = 3'h3;
  localparam logic [2:0] SUB_LOAD_CTRL   = 3'h4;
  localparam logic [2:0] SUB_RESET       = 3'h5;

  // Offset indices that read the data port instead of an offset register
  localparam logic [2:0] OFS_DATA_HI = 3'h7;
  localparam logic [2:0] OFS_DATA_LO = 3'h3;

  // ===========================================================================
  // Control word bits and reset values
  localparam int unsigned CR_COND_ALT = 10;
  localparam int unsigned CR_POST_UPD = 9;
  localparam int unsigned CR_PREC_HI  = 5;
  localparam int unsigned CR_PREC_LO  = 4;
  localparam logic [CR_W-1:0]   CR_RESET  = 11'h000;
  localparam logic [ALT_W-1:0]  ALT_RESET = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] MASK_DBL  = 16'h7FFF;
  localparam logic [ADDR_W-1:0] MASK_SGL  = 16'hFFFF;

  typedef enum logic [1:0] {
    PREC_SINGLE = 2'b00,
    PREC_DBL_LSW = 2'b01,
    PREC_DBL_MSW = 2'b10,
    PREC_DBL_ONE = 2'b11
  } precision_e;

endpackage

/* alu_if.sv */
// Operand and result bundle between the decoder and the update unit.
// Assumes a purely combinational consumer on the alu side.
`timescale 1ns/1ps
interface alu_if;
  logic [3:0]                     op;
  logic [addr_gen_pkg::ADDR_W-1:0] src;
  logic [addr_gen_pkg::ADDR_W-1:0] offset;
  logic [addr_gen_pkg::ADDR_W-1:0] result;
  modport alu (input op, input src, input offset, output result);
  modport ctl (output op, output src, output offset, input result);
endinterface

/* addr_update_alu.sv */
// Combinational update unit: add, subtract, step, logic, shift and bit reverse.
// Assumes the caller masks the result for double precision.
`timescale 1ns/1ps
module addr_update_alu (
  // Operands and result
  alu_if.alu bus
);

  // ===========================================================================
  // Bit reverse
  logic [addr_gen_pkg::ADDR_W-1:0] rev;
  genvar k;
  generate
    for (k = 0; k < addr_gen_pkg::ADDR_W; k++) begin : g_rev
      assign rev[k] = bus.src[addr_gen_pkg::ADDR_W-1-k];
    end
  endgenerate

  // ===========================================================================
  // Operation select
  always_comb begin
    unique case (bus.op)
      addr_gen_pkg::OP_LOOP_ADD:  bus.result = bus.src + bus.offset;
      addr_gen_pkg::OP_LOOP_SUB:  bus.result = bus.src - bus.offset;
      addr_gen_pkg::OP_LOOP_INC:  bus.result = bus.src + 16'h0001;
      addr_gen_pkg::OP_LOOP_DEC:  bus.result = bus.src - 16'h0001;
      addr_gen_pkg::OP_LOGIC_OR:  bus.result = bus.src | bus.offset;
      addr_gen_pkg::OP_LOGIC_AND: bus.result = bus.src & bus.offset;
      addr_gen_pkg::OP_LOGIC_XOR: bus.result = bus.src ^ bus.offset;
      addr_gen_pkg::OP_ASR:       bus.result = {bus.src[15], bus.src[15:1]};
      addr_gen_pkg::OP_LSL:       bus.result = {bus.src[14:0], 1'b0};
      addr_gen_pkg::OP_BIT_REV:   bus.result = rev;
      default:                    bus.result = bus.src;
    endcase
  end

endmodule

/* addr_gen_operand_and_alt_instr.sv */
// Operand selection, alternate instruction and precision control of the address generator.
// Assumes instruction, enables and data arrive synchronous to sys_clk_i and are latched
// together; results appear on the outputs at the edge after the latching edge.
//
// Functional notes
// (RL1) Data port select replaces the address register operand for address-output ops.
// (RL2) A data-port operand's updated address is written to the named address register.
// (RL3) Post-update with data port: read, modify and drive the address in one step.
// (RL4) Transfers with data port select take the data port as their source.
// (RL5) Offset index 7 or 3 reads the offset from the data port.
// (RL6) Alternate word of 10 bits runs instead of the port word while enabled.
// (RL7) Alternate enable is latched in the same stage as the instruction.
// (RL8) Alternate register never stores data port select; caller asserts it alongside.
// (RL9) Conditional alternate: true loop compare runs the alternate word next cycle.
// (RL10) Conditional alternate mode suppresses reinitialisation; update always written back.
// (RL11) Instructions without an address output float the port; no-op does nothing else.
// (RL12) Write-alternate loads the alternate register from data bits nine to zero.
// (RL13) Capture-alternate with data port select stores the next port word.
// (RL14) Reset decoded apart with top priority; reset from alternate is a no-op.
// (RL15) Reset at the port always runs, even right after capture-alternate.
// (RL16) Control bits five and four select one of four precision modes.
// (RL17) Bit reverse is not executed in either double-precision mode.
// (RL18) One-chip double: two steps per address, no reinit, no conditional alternate.
// (RL19) Two-chip double: reinit only for step ops; conditional alternate stays.
// (RL20) Single gives 16-bit addresses; double gives 15-bit words.
// (RL21) Single precision drives all 16 bits and allows every instruction.
// (RL22) Set-precision writes the two precision bits.
// (RL23) Increasing loops flag at or above compare; decreasing at or below.
// (RL24) Control bits three to zero enable reinit from matching init register.
`timescale 1ns/1ps
module addr_gen_operand_and_alt_instr (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Microcode side
  input  wire logic [9:0]  instr_i,
  input  wire logic        data_port_select_i,
  input  wire logic        alt_instr_enable_i,
  input  wire logic [15:0] data_i,
  // Address side
  output logic      [15:0] addr_o,
  output logic             addr_oe_n_o,
  output logic             compare_zero_flag_out_o
);

  // ===========================================================================
  // Input stage
  logic [9:0]  instr_q;
  logic        aen_q;
  logic        data_port_select_q;
  logic [15:0] data_q;

  always_ff @(posedge sys_clk_i) begin
    instr_q <= instr_i;
    aen_q   <= alt_instr_enable_i;  // see (RL7)
    data_port_select_q  <= data_port_select_i;
    data_q  <= data_i;
  end

  // ===========================================================================
  // State
  logic [15:0]                        r_file [addr_gen_pkg::NUM_R];
  logic [15:0]                        b_file [addr_gen_pkg::NUM_B];
  logic [15:0]                        c_file [addr_gen_pkg::NUM_CI];
  logic [15:0]                        i_file [addr_gen_pkg::NUM_CI];
  logic [addr_gen_pkg::CR_W-1:0]      control_word;
  logic [addr_gen_pkg::ALT_W-1:0]     alternate_instruction;
  logic                               cond_alt_pend;
  logic                               capture_pend;
  logic                               msw_phase;

  // ===========================================================================
  // Instruction selection
  wire       use_alt    = aen_q | cond_alt_pend;                                // see (RL6)
  wire [2:0] port_sub   = instr_q[addr_gen_pkg::FA_HI:addr_gen_pkg::FA_LO];
  wire       port_reset = instr_q[addr_gen_pkg::OPC_HI:addr_gen_pkg::OPC_LO]
                          == addr_gen_pkg::OP_MISC && port_sub == addr_gen_pkg::SUB_RESET;
  wire       capturing  = capture_pend & ~port_reset;                          // see (RL15)
  wire [9:0] exec_word  = use_alt ? alternate_instruction : instr_q;
  wire [3:0] opc        = exec_word[addr_gen_pkg::OPC_HI:addr_gen_pkg::OPC_LO];
  wire [2:0] fa         = exec_word[addr_gen_pkg::FA_HI:addr_gen_pkg::FA_LO];
  wire [2:0] fb         = exec_word[addr_gen_pkg::FB_HI:addr_gen_pkg::FB_LO];
  wire [1:0] cj         = fb[1:0];
  // A reset word held in the alternate register falls through as a no-op
  wire       live       = ~port_reset & ~capturing;                            // see (RL14)

  // ===========================================================================
  // Precision
  addr_gen_pkg::precision_e prec;
  assign prec = addr_gen_pkg::precision_e'(control_word[addr_gen_pkg::CR_PREC_HI:
                                                        addr_gen_pkg::CR_PREC_LO]); // see (RL16)
  wire dbl     = prec != addr_gen_pkg::PREC_SINGLE;
  wire one_chp = prec == addr_gen_pkg::PREC_DBL_ONE;
  wire two_chp = dbl & ~one_chp;
  wire [15:0] word_mask = dbl ? addr_gen_pkg::MASK_DBL : addr_gen_pkg::MASK_SGL; // see (RL20)

  // ===========================================================================
  // Decode
  wire is_add  = live & opc == addr_gen_pkg::OP_LOOP_ADD;
  wire is_sub  = live & opc == addr_gen_pkg::OP_LOOP_SUB;
  wire is_inc  = live & opc == addr_gen_pkg::OP_LOOP_INC;
  wire is_dec  = live & opc == addr_gen_pkg::OP_LOOP_DEC;
  wire is_loop = is_add | is_sub | is_inc | is_dec;
  wire is_alu  = live & (opc >= addr_gen_pkg::OP_LOGIC_OR) & (opc <= addr_gen_pkg::OP_LSL);
  wire is_xr   = live & opc == addr_gen_pkg::OP_XFER_ADDR;
  wire is_xb   = live & opc == addr_gen_pkg::OP_XFER_OFS;
  wire is_xc   = live & opc == addr_gen_pkg::OP_XFER_CMP;
  wire is_xfer = is_xr | is_xb | is_xc;
  wire is_rev  = live & opc == addr_gen_pkg::OP_BIT_REV & ~dbl;                // see (RL17)
  wire is_misc = live & opc == addr_gen_pkg::OP_MISC;
  wire do_wra  = is_misc & fa == addr_gen_pkg::SUB_WRITE_ALT;
  wire do_lda  = is_misc & fa == addr_gen_pkg::SUB_CAPTURE_ALT & data_port_select_q;       // see (RL13)
  wire do_set_precision_op = is_misc & fa == addr_gen_pkg::SUB_SET_PREC;
  wire do_dti  = is_misc & fa == addr_gen_pkg::SUB_LOAD_INIT;
  wire do_dtcr = is_misc & fa == addr_gen_pkg::SUB_LOAD_CTRL;
  // Single precision reaches every class; double only loses bit reverse
  wire outputs = is_loop | is_alu | is_xfer | is_rev;                          // see (RL21)

  // ===========================================================================
  // Operands
  wire [15:0] src = data_port_select_q ? data_q : r_file[fa];                              // see (RL1)
  wire ofs_dp     = fb == addr_gen_pkg::OFS_DATA_HI | fb == addr_gen_pkg::OFS_DATA_LO;
  wire [15:0] ofs = ofs_dp ? data_q : b_file[fb];                              // see (RL5)

  alu_if alu_bus ();
  assign alu_bus.op     = is_rev ? addr_gen_pkg::OP_BIT_REV : opc;
  assign alu_bus.src    = src & word_mask;
  assign alu_bus.offset = ofs & word_mask;

  addr_update_alu u_alu (
    .bus (alu_bus)
  );

  wire [15:0] upd    = alu_bus.result & word_mask;
  wire        post   = control_word[addr_gen_pkg::CR_POST_UPD];
  // Post-update sends the modified data-port value out in the same step
  wire [15:0] y_val  = (post & ~is_xfer) ? upd : (src & word_mask);            // see (RL3)

  // ===========================================================================
  // Compare and reinitialisation
  wire [15:0] cval     = c_file[cj] & word_mask;
  wire        rising   = is_add | is_inc;
  wire        cmp_hit  = is_loop & (rising ? (y_val >= cval) : (y_val <= cval)); // see (RL23)
  wire        cond_alt = control_word[addr_gen_pkg::CR_COND_ALT];
  wire        reinit_ok = is_loop & control_word[cj] & ~cond_alt & ~one_chp     // see (RL24)
                          & ~(two_chp & (is_add | is_sub));                    // see (RL19)
  wire        do_reinit = reinit_ok & cmp_hit;                                 // see (RL10)
  // One-chip double gives up the conditional alternate; two-chip keeps it
  wire        set_cond  = cmp_hit & cond_alt & ~one_chp;                       // see (RL9) (RL18)
  wire        writes_r  = is_loop | is_alu | is_rev | is_xr;
  wire [15:0] next_r    = do_reinit ? i_file[cj] : (is_xr ? src : upd);        // see (RL2) (RL4)
  wire [1:0]  next_prec = fb[1:0] ^ {2{data_port_select_q}};

  // ===========================================================================
  // Register files
  always_ff @(posedge sys_clk_i) begin
    if (writes_r) begin
      r_file[fa] <= next_r;                                                    // see (RL2)
    end
    if (is_xb) begin
      b_file[fb] <= src;                                                       // see (RL4)
    end
    if (is_xc) begin
      c_file[cj] <= src;
    end
    if (do_dti) begin
      i_file[cj] <= data_q;
    end
  end

  // ===========================================================================
  // Control word and alternate register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || port_reset) begin
      control_word <= addr_gen_pkg::CR_RESET;                                  // see (RL14)
    end else if (do_dtcr) begin
      control_word <= data_q[addr_gen_pkg::CR_W-1:0];
    end else if (do_set_precision_op) begin
      control_word[addr_gen_pkg::CR_PREC_HI:addr_gen_pkg::CR_PREC_LO] <= next_prec; // see (RL22)
    end
  end

  // Only the ten-bit word is kept; data port select is never stored
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      alternate_instruction <= addr_gen_pkg::ALT_RESET;
    end else if (capturing) begin
      alternate_instruction <= instr_q;                                        // see (RL13) (RL8)
    end else if (do_wra) begin
      alternate_instruction <= data_q[addr_gen_pkg::ALT_W-1:0];                // see (RL12)
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || port_reset) begin
      cond_alt_pend <= 1'b0;
      capture_pend  <= 1'b0;
      msw_phase     <= 1'b0;
    end else begin
      cond_alt_pend <= set_cond;                                               // see (RL9)
      capture_pend  <= do_lda;
      if (one_chp && outputs) begin
        msw_phase <= ~msw_phase;                                               // see (RL18)
      end
    end
  end

  // ===========================================================================
  // Outputs
  wire [15:0] next_addr = one_chp ? {msw_phase, y_val[14:0]} : y_val;         // see (RL20)
  wire        next_flag = is_loop ? cmp_hit : (y_val == addr_gen_pkg::ADDR_ZERO);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      addr_o                  <= addr_gen_pkg::ADDR_ZERO;
      addr_oe_n_o             <= 1'b1;
      compare_zero_flag_out_o <= 1'b0;
    end else begin
      addr_o                  <= outputs ? next_addr : addr_gen_pkg::ADDR_ZERO;
      addr_oe_n_o             <= ~outputs;                                     // see (RL11)
      compare_zero_flag_out_o <= outputs & next_flag;
    end
  end

  // ===========================================================================
  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_capture_armed;
    do_lda ##1 !port_reset;
  endsequence

  a_alt_write_low: assert property (do_wra && !capturing |=>           // see (RL12)
    alternate_instruction == $past(data_q[9:0]))
    else $error("alternate not loaded from data bits");

  a_capture_next_word: assert property (s_capture_armed |=>            // see (RL13)
    alternate_instruction == $past(instr_q))
    else $error("capture did not store the following port word");

  a_no_output_float: assert property (!outputs |=> addr_oe_n_o)        // see (RL11)
    else $error("address port driven without an output instruction");

  a_port_reset_wins: assert property (port_reset |=>                   // see (RL15)
    control_word == addr_gen_pkg::CR_RESET && !capture_pend)
    else $error("port reset did not take effect");

  a_cond_alt_next: assert property (is_loop && cmp_hit && cond_alt && !one_chp
    && !port_reset |=> use_alt)                                            // see (RL9)
    else $error("conditional alternate not raised after compare");

  a_no_reinit_cond: assert property (cond_alt && is_loop |->            // see (RL10)
    next_r == upd)
    else $error("reinitialisation under conditional alternate");

  a_data_port_select_source: assert property (outputs && data_port_select_q && !post && !one_chp |=> // see (RL1)
    addr_o == $past(data_q & word_mask))
    else $error("data port operand not output");

  a_rev_blocked_dbl: assert property (dbl && opc == addr_gen_pkg::OP_BIT_REV |=> // see (RL17)
    addr_oe_n_o)
    else $error("bit reverse executed in double precision");

  a_one_chip_phase: assert property (one_chp && outputs && !port_reset |=> // see (RL18)
    msw_phase != $past(msw_phase))
    else $error("one-chip word phase did not advance");

  a_set_precision_op_bits: assert property (do_set_precision_op && !do_dtcr |=>                 // see (RL22)
    control_word[5:4] == $past(next_prec))
    else $error("precision bits not written");

endmodule

/* microcode_source.sv */
// Microcode source model: presents instruction, selects and data to the front end.
// Assumes the bench sets each request before the falling edge that presents it.
`timescale 1ns/1ps
module microcode_source (
  // Clock
  input  wire logic        sys_clk_i,
  // Request from the bench
  input  wire logic [9:0]  req_instr_i,
  input  wire logic        req_data_port_select_i,
  input  wire logic        req_alt_instr_enable_i,
  input  wire logic        req_dv_i,
  input  wire logic [15:0] req_data_i,
  // Microcode side of the front end
  output logic      [9:0]  instr_o = 10'h000,
  output logic             data_port_select_o  = 1'b0,
  output logic             alt_instr_enable_o  = 1'b0,
  output logic      [15:0] data_o  = 16'h0000
);
  // ==========================================================================
  // Presentation
  // Words change at the falling edge so the rising edge sees them settled
  always @(negedge sys_clk_i) begin
    instr_o <= req_instr_i;
    alt_instr_enable_o  <= req_alt_instr_enable_i;
    data_port_select_o  <= req_data_port_select_i;
    // An unused data bus does not keep its last value
    data_o  <= req_dv_i ? req_data_i : ~data_o;
  end
endmodule

/* tb_addr_gen_operand_and_alt_instr.sv */
// Self-checking bench of the operand, alternate and precision front end.
// Assumes the design answers one rising edge after the edge that latches a word.
`timescale 1ns/1ps
module tb_addr_gen_operand_and_alt_instr;
  // ==========================================================================
  // Short opcode names
  localparam logic [3:0]  op_nop = addr_gen_pkg::OP_NOP;
  localparam logic [3:0]  op_inc = addr_gen_pkg::OP_LOOP_INC;
  localparam logic [3:0]  op_dec = addr_gen_pkg::OP_LOOP_DEC;
  localparam logic [3:0]  op_xa  = addr_gen_pkg::OP_XFER_ADDR;
  localparam logic [15:0] all    = 16'hFFFF;
  // ==========================================================================
  // Signals
  logic        sys_clk_i;
  logic        rst_i;
  logic [9:0]  rq_w;
  logic        rq_s;
  logic        rq_a;
  logic        rq_v;
  logic [15:0] rq_d;
  logic [9:0]  instr_i;
  logic        data_port_select_i;
  logic        alt_instr_enable_i;
  logic [15:0] data_i;
  logic [15:0] addr_o;
  logic        addr_oe_n_o;
  logic        compare_zero_flag_out_o;
  logic [31:0] seed;
  logic [15:0] v;
  logic [15:0] c;
  logic [15:0] d;
  logic [15:0] e;
  logic [9:0]  i12;
  logic [9:0]  nop;
  int          bad_count;
  int          checked;
  int          cycles;
  int          i;

  microcode_source src (.sys_clk_i(sys_clk_i), .req_instr_i(rq_w), .req_data_port_select_i(rq_s),
    .req_alt_instr_enable_i(rq_a), .req_dv_i(rq_v), .req_data_i(rq_d), .instr_o(instr_i),
    .data_port_select_o(data_port_select_i), .alt_instr_enable_o(alt_instr_enable_i), .data_o(data_i));
  addr_gen_operand_and_alt_instr DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .instr_i(instr_i), .data_port_select_i(data_port_select_i),
    .alt_instr_enable_i(alt_instr_enable_i), .data_i(data_i), .addr_o(addr_o),
    .addr_oe_n_o(addr_oe_n_o), .compare_zero_flag_out_o(compare_zero_flag_out_o));

  // ==========================================================================
  // Helpers
  function automatic logic [9:0] mk(input logic [3:0] o, input logic [2:0] a,
                                    input logic [2:0] b);
    return {o, a, b};
  endfunction
  function automatic logic [9:0] misc(input logic [2:0] s, input logic [2:0] b);
    return {addr_gen_pkg::OP_MISC, s, b};
  endfunction
  // Kept clear of the top so loop arithmetic never wraps
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return (seed[15:0] & 16'h7EFF) | 16'h0001;
  endfunction
  task automatic put(input logic [9:0] w, input logic s, input logic a, input logic dv,
                     input logic [15:0] dd);
    @(posedge sys_clk_i);
    rq_w = w;
    rq_s = s;
    rq_a = a;
    rq_v = dv;
    rq_d = dd;
    @(negedge sys_clk_i);
  endtask
  // One word, then a filler, then sample where its answer stands
  task automatic exec(input logic [9:0] w, input logic s, input logic a, input logic [15:0] dd);
    put(w, s, a, 1'b1, dd);
    put(nop, 1'b0, 1'b0, 1'b0, 16'h0000);
    @(negedge sys_clk_i);
  endtask
  task automatic chk(input logic oen, input logic [15:0] ea, input logic [15:0] m,
                     input logic f);
    checked++;
    if (addr_oe_n_o !== oen || (addr_o & m) !== (ea & m) || compare_zero_flag_out_o !== f) begin
      bad_count++;
      $display("MISMATCH at %0t: oe_n %b addr %h flag %b", $time, addr_oe_n_o, addr_o,
               compare_zero_flag_out_o);
    end
  endtask
  task automatic chk_oe(input logic oen);
    checked++;
    if (addr_oe_n_o !== oen) begin
      bad_count++;
      $display("MISMATCH at %0t: oe_n %b", $time, addr_oe_n_o);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================================
  // Clock and timeout
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      $display("MISMATCH at %0t: timeout", $time);
      give_verdict();
    end
  end

  // ==========================================================================
  // Scenarios
  initial begin
    {rq_w, rq_s, rq_a, rq_v, rq_d} = '0;
    {bad_count, checked, cycles} = '0;
    rst_i = 1'b1;
    seed = 32'hEB510432;
    nop = mk(op_nop, 3'h0, 3'h0);
    i12 = mk(op_inc, 3'h1, 3'h2);
    repeat (12) @(negedge sys_clk_i);
    chk(1'b1, 16'h0000, all, 1'b0);
    rst_i = 1'b0;
    for (i = 0; i < 8; i++) begin
      d = (i == 0) ? 16'h0000 : rnd();
      exec(mk(op_xa, i[2:0], 3'h0), 1'b1, 1'b0, d);
      chk(1'b0, d, all, d == 16'h0000);
    end
    v = rnd();
    c = v + 16'h0001;
    exec(mk(addr_gen_pkg::OP_XFER_CMP, 3'h0, 3'h2), 1'b1, 1'b0, c);
    chk(1'b0, c, all, 1'b0);
    exec(mk(op_xa, 3'h1, 3'h0), 1'b1, 1'b0, v);
    exec(i12, 1'b0, 1'b0, rnd());
    chk(1'b0, v, all, 1'b0);
    exec(i12, 1'b0, 1'b0, rnd());
    chk(1'b0, c, all, 1'b1);
    exec(mk(op_dec, 3'h1, 3'h2), 1'b0, 1'b0, rnd());
    chk(1'b0, v + 16'h0002, all, 1'b0);
    exec(mk(op_dec, 3'h1, 3'h2), 1'b0, 1'b0, rnd());
    chk(1'b0, c, all, 1'b1);
    d = v + 16'h0100;
    exec(i12, 1'b1, 1'b0, d);
    chk(1'b0, d, all, 1'b1);
    exec(i12, 1'b0, 1'b0, rnd());
    chk(1'b0, d + 16'h0001, all, 1'b1);
    e = rnd() & 16'h00FF;
    exec(mk(addr_gen_pkg::OP_LOOP_ADD, 3'h1, 3'h7), 1'b0, 1'b0, e);
    exec(i12, 1'b0, 1'b0, rnd());
    chk(1'b0, d + 16'h0002 + e, all, 1'b1);
    exec(nop, 1'b1, 1'b0, rnd());
    chk(1'b1, 16'h0000, all, 1'b0);
    $display("test operands done");
    exec(misc(addr_gen_pkg::SUB_WRITE_ALT, 3'h0), 1'b0, 1'b0, {6'h2A, mk(op_xa, 3'h2, 3'h0)});
    d = rnd();
    exec(nop, 1'b1, 1'b1, d);
    chk(1'b0, d, all, 1'b0);
    exec(nop, 1'b1, 1'b0, rnd());
    chk_oe(1'b1);
    exec(nop, 1'b0, 1'b1, rnd());
    chk(1'b0, d, all, 1'b0);
    e = rnd();
    put(misc(addr_gen_pkg::SUB_CAPTURE_ALT, 3'h0), 1'b1, 1'b0, 1'b1, 16'h0000);
    put(mk(op_xa, 3'h3, 3'h0), 1'b1, 1'b0, 1'b1, e);
    put(nop, 1'b0, 1'b0, 1'b0, 16'h0000);
    put(nop, 1'b0, 1'b0, 1'b0, 16'h0000);
    chk_oe(1'b1);
    exec(nop, 1'b1, 1'b1, d);
    chk(1'b0, d, all, 1'b0);
    put(misc(addr_gen_pkg::SUB_CAPTURE_ALT, 3'h0), 1'b0, 1'b0, 1'b1, 16'h0000);
    put(mk(op_xa, 3'h3, 3'h0), 1'b1, 1'b0, 1'b1, e);
    put(nop, 1'b0, 1'b0, 1'b0, 16'h0000);
    put(nop, 1'b0, 1'b0, 1'b0, 16'h0000);
    chk(1'b0, e, all, 1'b0);
    put(misc(addr_gen_pkg::SUB_CAPTURE_ALT, 3'h0), 1'b1, 1'b0, 1'b1, 16'h0000);
    put(misc(addr_gen_pkg::SUB_RESET, 3'h0), 1'b0, 1'b0, 1'b1, 16'h0000);
    exec(nop, 1'b1, 1'b1, e);
    chk(1'b0, e, all, 1'b0);
    $display("test alternate done");
    exec(misc(addr_gen_pkg::SUB_LOAD_CTRL, 3'h0), 1'b0, 1'b0, 16'h0200);
    d = rnd();
    exec(i12, 1'b1, 1'b0, d);
    chk(1'b0, d + 16'h0001, all, (d + 16'h0001) >= c);
    exec(misc(addr_gen_pkg::SUB_WRITE_ALT, 3'h0), 1'b0, 1'b0,
         {6'h00, misc(addr_gen_pkg::SUB_RESET, 3'h0)});
    exec(nop, 1'b0, 1'b1, 16'h0000);
    chk_oe(1'b1);
    exec(i12, 1'b1, 1'b0, d);
    chk(1'b0, d + 16'h0001, all, (d + 16'h0001) >= c);
    exec(misc(addr_gen_pkg::SUB_RESET, 3'h0), 1'b0, 1'b0, 16'h0000);
    exec(i12, 1'b1, 1'b0, d);
    chk(1'b0, d, all, d >= c);
    $display("test update mode done");
    exec(misc(addr_gen_pkg::SUB_WRITE_ALT, 3'h0), 1'b0, 1'b0, {6'h00, mk(op_xa, 3'h3, 3'h0)});
    exec(misc(addr_gen_pkg::SUB_LOAD_INIT, 3'h2), 1'b0, 1'b0, v);
    exec(mk(op_xa, 3'h1, 3'h0), 1'b1, 1'b0, v + 16'h0005);
    exec(misc(addr_gen_pkg::SUB_LOAD_CTRL, 3'h0), 1'b0, 1'b0, 16'h000F);
    exec(i12, 1'b0, 1'b0, rnd());
    chk(1'b0, v + 16'h0005, all, 1'b1);
    exec(i12, 1'b0, 1'b0, rnd());
    chk(1'b0, v, all, 1'b0);
    exec(mk(op_xa, 3'h1, 3'h0), 1'b1, 1'b0, v + 16'h0005);
    exec(misc(addr_gen_pkg::SUB_LOAD_CTRL, 3'h0), 1'b0, 1'b0, 16'h040F);
    put(i12, 1'b0, 1'b0, 1'b1, 16'h0000);
    put(nop, 1'b1, 1'b0, 1'b1, e);
    put(nop, 1'b0, 1'b0, 1'b0, 16'h0000);
    chk(1'b0, v + 16'h0005, all, 1'b1);
    put(nop, 1'b0, 1'b0, 1'b0, 16'h0000);
    chk(1'b0, e, all, 1'b0);
    exec(i12, 1'b0, 1'b0, rnd());
    chk(1'b0, v + 16'h0006, all, 1'b1);
    exec(misc(addr_gen_pkg::SUB_RESET, 3'h0), 1'b0, 1'b0, 16'h0000);
    $display("test conditional done");
    d = rnd();
    for (i = 1; i < 4; i++) begin
      exec(misc(addr_gen_pkg::SUB_SET_PREC, i[2:0]), 1'b0, 1'b0, 16'h0000);
      exec(mk(addr_gen_pkg::OP_BIT_REV, 3'h1, 3'h0), 1'b1, 1'b0, d);
      chk_oe(1'b1);
      exec(mk(op_xa, 3'h4, 3'h0), 1'b1, 1'b0, d);
      chk(1'b0, d, all, 1'b0);
    end
    exec(mk(op_xa, 3'h5, 3'h0), 1'b1, 1'b0, d);
    chk(1'b0, d | 16'h8000, all, 1'b0);
    // Data port select inverts both bits, so 11 lands on single precision
    exec(misc(addr_gen_pkg::SUB_SET_PREC, 3'h3), 1'b1, 1'b0, 16'h0000);
    exec(mk(addr_gen_pkg::OP_BIT_REV, 3'h1, 3'h0), 1'b1, 1'b0, d);
    chk_oe(1'b0);
    exec(mk(op_xa, 3'h4, 3'h0), 1'b1, 1'b0, 16'h8001);
    chk(1'b0, 16'h8001, all, 1'b0);
    $display("test precision done");
    give_verdict();
  end
endmodule
